/* vpw_pkg.sv */
package vpw_pkg;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] horizontal_window_addr = 12'h000;
   localparam logic [11:0] vertical_window_addr   = 12'h004;
   localparam logic [11:0] output_window_addr     = 12'h008;
   localparam logic [11:0] port_control_addr      = 12'h00c;
   localparam logic [11:0] port_status_addr       = 12'h010;

   // ----------------------------------------
   // field layout
   // ----------------------------------------
   localparam int window_start_lsb       = 16;
   localparam int window_count_lsb       = 0;
   localparam int output_line_count_lsb  = 17;
   localparam int output_pixel_count_lsb = 4;
   localparam int output_start_lsb       = 0;
   localparam int slice_select_lsb       = 12;
   localparam int port_enable_bit        = 15;

   localparam int count_w      = 13;
   localparam int line_count_w = 14;
   localparam int start_off_w  = 4;
   localparam int select_w     = 3;
   localparam int in_bus_w     = 16;
   localparam int pix_w        = 10;

   localparam logic [31:0] reset_value   = 32'h0000_0000;
   localparam logic [31:0] window_mask   = 32'h1fff_1fff;
   localparam logic [31:0] output_mask   = 32'h7fff_ffff;
   localparam logic [31:0] control_mask  = 32'h0000_f000;
   localparam logic [2:0]  reserved_sel  = 3'h7;

   typedef struct packed {
      logic [count_w-1:0]      start_pixel;
      logic [count_w-1:0]      pixel_count;
      logic [count_w-1:0]      start_line;
      logic [count_w-1:0]      line_count;
      logic [line_count_w-1:0] out_lines;
      logic [count_w-1:0]      out_pixels;
      logic [start_off_w-1:0]  out_start;
      logic [select_w-1:0]     slice_sel;
      logic                    enable;
   } window_cfg_t;

   typedef struct packed {
      logic           hsync;
      logic           vsync;
      logic           valid;
      logic [pix_w-1:0] data;
   } pixel_out_t;
endpackage

/* vpw_slice.sv */
module vpw_slice #(
   parameter int in_w  = 16,
   parameter int out_w = 10,
   parameter int sel_w = 3
) (
   input  wire logic [in_w-1:0]  bus_in,
   input  wire logic [sel_w-1:0] sel,
   output logic      [out_w-1:0] slice_out,
   output logic                  sel_bad
);
   if (out_w > in_w) begin : g_width_check
      $error("slice wider than bus");
   end

   // ----------------------------------------
   // slice select, code 0 takes the top bits
   // ----------------------------------------
   always_comb begin
      slice_out = '0;
      sel_bad   = 1'b0;
      if (int'(sel) > in_w - out_w) begin
         sel_bad = 1'b1; // R13
      end else begin
         slice_out = bus_in[(in_w - 1 - int'(sel)) -: out_w]; // R13
      end
   end
endmodule // vpw_slice

/* video_port_window_control.sv */
// Function
// R1: horizontal window opens at start-pixel count after hsync begins.
// R2: horizontal window width equals the 13-bit pixel count field.
// R3: vertical window opens at start-line count after vsync begins.
// R4: vertical window height equals the 13-bit line count field.
// R5: port outputs exactly the programmed line count, then stops.
// R6: output feeds downstream engines; each consumes it when selected.
// R7: software sets output lines below sensor lines per frame.
// R8: output vsync comes straight from first incoming vsync.
// R9: each output line carries the programmed pixel count.
// R10: output hsync placed at 4-bit start offset, 0 to 15.
// R11: offsets above 15 need the input window moved instead.
// R12: per-line offset lets port crop parallelogram sensor images.
// R13: 10-bit input slice chosen by 3-bit code; code 7 reserved.
// R14: counters restart on active sync edge, advance per valid pixel.
// R15: fields reset to zero; reserved bits read zero, ignore writes.
//
// Design decisions made here: the APB register port and the register offsets.
module video_port_window_control (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic [15:0]             sensor_data,
   input  wire logic                    pixel_valid,
   input  wire logic                    horizontal_sync_in,
   input  wire logic                    vertical_sync_in,
   output vpw_pkg::pixel_out_t          window_out,
   output logic                         window_in_active,
   output vpw_pkg::pixel_out_t          port_out
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [31:0] horiz_r, horiz_nxt;
   logic [31:0] vert_r, vert_nxt;
   logic [31:0] vport_r, vport_nxt;
   logic [31:0] ctrl_r, ctrl_nxt;
   logic [31:0] prdata_nxt;
   logic        pready_nxt, pslverr_nxt;
   vpw_pkg::window_cfg_t cfg;
   logic        access, wr, rd_hit;
   logic [31:0] status;

   assign access = psel && penable && !pready;

   always_comb begin
      cfg.start_pixel = horiz_r[vpw_pkg::window_start_lsb +: vpw_pkg::count_w]; // R1
      cfg.pixel_count = horiz_r[vpw_pkg::window_count_lsb +: vpw_pkg::count_w]; // R2
      cfg.start_line  = vert_r[vpw_pkg::window_start_lsb +: vpw_pkg::count_w]; // R3
      cfg.line_count  = vert_r[vpw_pkg::window_count_lsb +: vpw_pkg::count_w]; // R4
      cfg.out_lines   = vport_r[vpw_pkg::output_line_count_lsb +:
                                vpw_pkg::line_count_w]; // R5
      cfg.out_pixels  = vport_r[vpw_pkg::output_pixel_count_lsb +:
                                vpw_pkg::count_w]; // R9
      cfg.out_start   = vport_r[vpw_pkg::output_start_lsb +:
                                vpw_pkg::start_off_w]; // R10
      cfg.slice_sel   = ctrl_r[vpw_pkg::slice_select_lsb +: vpw_pkg::select_w];
      cfg.enable      = ctrl_r[vpw_pkg::port_enable_bit];
   end

   // ----------------------------------------
   // apb slave, one wait state per access
   // ----------------------------------------
   always_comb begin
      horiz_r_next_default: begin
         horiz_nxt   = horiz_r;
         vert_nxt    = vert_r;
         vport_nxt   = vport_r;
         ctrl_nxt    = ctrl_r;
         prdata_nxt  = prdata;
         pready_nxt  = access;
         pslverr_nxt = 1'b0;
         wr          = access && pwrite;
         rd_hit      = 1'b1;
      end
      if (access) begin
         prdata_nxt = 32'h0000_0000;
         unique case (paddr)
            vpw_pkg::horizontal_window_addr: begin
               if (wr) horiz_nxt = pwdata & vpw_pkg::window_mask; // R15
               prdata_nxt = horiz_r;
            end
            vpw_pkg::vertical_window_addr: begin
               if (wr) vert_nxt = pwdata & vpw_pkg::window_mask; // R15
               prdata_nxt = vert_r;
            end
            vpw_pkg::output_window_addr: begin
               if (wr) vport_nxt = pwdata & vpw_pkg::output_mask; // R15
               prdata_nxt = vport_r;
            end
            vpw_pkg::port_control_addr: begin
               if (wr) ctrl_nxt = pwdata & vpw_pkg::control_mask; // R15
               prdata_nxt = ctrl_r;
            end
            vpw_pkg::port_status_addr: begin
               prdata_nxt = status;
            end
            default: begin
               rd_hit = 1'b0;
            end
         endcase
         pslverr_nxt = !rd_hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         horiz_r <= vpw_pkg::reset_value; // R15
         vert_r  <= vpw_pkg::reset_value;
         vport_r <= vpw_pkg::reset_value;
         ctrl_r  <= vpw_pkg::reset_value;
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         horiz_r <= horiz_nxt;
         vert_r  <= vert_nxt;
         vport_r <= vport_nxt;
         ctrl_r  <= ctrl_nxt;
         prdata  <= prdata_nxt;
         pready  <= pready_nxt;
         pslverr <= pslverr_nxt;
      end
   end

   // ----------------------------------------
   // input slice
   // ----------------------------------------
   logic [vpw_pkg::pix_w-1:0] slice;
   logic                      sel_bad;

   vpw_slice #(
      .in_w  (vpw_pkg::in_bus_w),
      .out_w (vpw_pkg::pix_w),
      .sel_w (vpw_pkg::select_w)
   ) u_slice (
      .bus_in    (sensor_data),
      .sel       (cfg.slice_sel),
      .slice_out (slice),
      .sel_bad   (sel_bad)
   );

   // ----------------------------------------
   // counters
   // ----------------------------------------
   logic        hs_d_r, hs_d_nxt, vs_d_r, vs_d_nxt;
   logic [12:0] pix_r, pix_nxt, line_r, line_nxt;
   logic [13:0] out_line_r, out_line_nxt;
   logic        frame_r, frame_nxt, line_done_r, line_done_nxt;
   logic        hs_rise, vs_rise, h_in, v_in, port_on;
   logic [13:0] o_first, o_last;
   logic        o_in;

   assign hs_rise = horizontal_sync_in && !hs_d_r;
   assign vs_rise = vertical_sync_in && !vs_d_r;

   // window membership; widened to avoid start+count overflow
   assign h_in = ({1'b0, pix_r} >= {1'b0, cfg.start_pixel}) &&
                 ({1'b0, pix_r} < ({1'b0, cfg.start_pixel} +
                                   {1'b0, cfg.pixel_count})); // R1 R2
   assign v_in = ({1'b0, line_r} >= {1'b0, cfg.start_line}) &&
                 ({1'b0, line_r} < ({1'b0, cfg.start_line} +
                                    {1'b0, cfg.line_count})); // R3 R4
   // output line begins at the 0..15 offset inside the window
   assign o_first = {1'b0, cfg.start_pixel} + {10'h000, cfg.out_start}; // R10 R12
   assign o_last  = o_first + {1'b0, cfg.out_pixels};
   assign o_in    = ({1'b0, pix_r} >= o_first) && ({1'b0, pix_r} < o_last); // R9
   assign port_on = cfg.enable && !sel_bad && frame_r &&
                    (out_line_r < cfg.out_lines) && v_in; // R5

   always_comb begin
      hs_d_nxt      = horizontal_sync_in;
      vs_d_nxt      = vertical_sync_in;
      pix_nxt       = pix_r;
      line_nxt      = line_r;
      out_line_nxt  = out_line_r;
      frame_nxt     = frame_r;
      line_done_nxt = line_done_r;
      if (vs_rise) begin
         line_nxt     = 13'h0000; // R14
         out_line_nxt = 14'h0000;
         frame_nxt    = cfg.enable; // R8
      end else if (hs_rise) begin
         line_nxt = line_r + 13'h0001; // R14
      end
      if (hs_rise) begin
         pix_nxt       = 13'h0000; // R14
         line_done_nxt = 1'b0;
         if (line_done_r && !vs_rise) begin
            out_line_nxt = out_line_r + 14'h0001; // R5
         end
      end else if (pixel_valid) begin
         pix_nxt = pix_r + 13'h0001; // R14
         if (port_on && o_in) line_done_nxt = 1'b1;
      end
   end

   // ----------------------------------------
   // output stream, registered
   // ----------------------------------------
   vpw_pkg::pixel_out_t win_nxt, port_nxt;
   logic                win_act_nxt;

   always_comb begin
      win_act_nxt   = h_in && v_in;
      win_nxt.data  = slice;
      win_nxt.valid = pixel_valid && h_in && v_in;
      win_nxt.hsync = horizontal_sync_in;
      win_nxt.vsync = vertical_sync_in;
      port_nxt.data  = slice; // R6
      port_nxt.valid = pixel_valid && port_on && o_in; // R6 R9
      // hsync marks the first pixel of each output line
      port_nxt.hsync = pixel_valid && port_on && (pix_r == o_first[12:0]); // R10
      port_nxt.vsync = vertical_sync_in && cfg.enable; // R8
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_d_r           <= 1'b0;
         vs_d_r           <= 1'b0;
         pix_r            <= 13'h0000;
         line_r           <= 13'h0000;
         out_line_r       <= 14'h0000;
         frame_r          <= 1'b0;
         line_done_r      <= 1'b0;
         window_out       <= '0;
         window_in_active <= 1'b0;
         port_out         <= '0;
      end else begin
         hs_d_r           <= hs_d_nxt;
         vs_d_r           <= vs_d_nxt;
         pix_r            <= pix_nxt;
         line_r           <= line_nxt;
         out_line_r       <= out_line_nxt;
         frame_r          <= frame_nxt;
         line_done_r      <= line_done_nxt;
         window_out       <= win_nxt;
         window_in_active <= win_act_nxt;
         port_out         <= port_nxt;
      end
   end

   assign status = {17'h00000, frame_r, out_line_r};
endmodule // video_port_window_control

/* vpw_checker.sv */
// ----------------------------------------
// port checker
// ----------------------------------------
module vpw_checker (
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [11:0]         paddr,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire logic                pixel_valid,
   input wire logic                vertical_sync_in,
   input wire vpw_pkg::pixel_out_t port_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_answer: assert property (psel && penable && !pready |=> pready)
      else $error("no answer one cycle after access");
   a_ready_held: assert property (pready |-> psel && penable)
      else $error("pready outside an access");
   a_err_unmapped: assert property (pready && paddr > 12'h010 |-> pslverr)
      else $error("unmapped access not refused");
   a_err_mapped: assert property (pready && paddr <= 12'h010 &&
      paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access refused");
   a_err_read_zero: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("refused read returned data");
   a_rdata_hold: assert property (!pready |-> $stable(prdata))
      else $error("read data moved between accesses");
   a_vsync_follow: assert property (port_out.vsync |-> $past(vertical_sync_in))
      else $error("output vsync without input vsync");
   a_valid_cause: assert property (port_out.valid |-> $past(pixel_valid))
      else $error("output pixel without input pixel");
   a_hsync_first: assert property (port_out.hsync |-> port_out.valid ##1 !port_out.hsync)
      else $error("output hsync not a single pixel mark");
   c_line: cover property (port_out.hsync);
   c_frame: cover property (port_out.vsync);
   c_refused: cover property (pready && pslverr);
endmodule // vpw_checker

bind video_port_window_control vpw_checker u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pixel_valid(pixel_valid), .vertical_sync_in(vertical_sync_in),
   .port_out(port_out));

/* engine_model.sv */
// ----------------------------------------
// downstream engine: counts what it takes
// ----------------------------------------
module engine_model (
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                consume,
   input wire vpw_pkg::pixel_out_t port_out,
   output int                      lines,
   output int                      pixels,
   output logic [9:0]              first_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // totals clear only at reset: the bench works on differences per frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lines <= 0;
         pixels <= 0;
         first_data <= 10'h000;
      end else if (consume && port_out.valid === 1'b1) begin
         pixels <= pixels + 1;
         if (port_out.hsync === 1'b1) begin
            lines <= lines + 1;
            first_data <= port_out.data;
         end
      end
   end
endmodule // engine_model

/* video_port_window_control_tb.sv */
module video_port_window_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                pclk, presetn, psel, penable, pwrite, pixel_valid;
   logic                pready, pslverr, err, window_in_active;
   logic                horizontal_sync_in, vertical_sync_in;
   logic [11:0]         paddr;
   logic [31:0]         pwdata, prdata, rd;
   logic [15:0]         sensor_data;
   logic [9:0]          first_a;
   vpw_pkg::pixel_out_t window_out, port_out;
   int                  lines_a, pixels_a, lines_b, pixels_b;
   int                  failures, n_compared;
   int                  win_px, win_act, win_syn, port_vs;
   int                  st, win_exp, act_exp;
   logic [9:0]          win_first;
   logic                win_prev;

   video_port_window_control dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sensor_data(sensor_data), .pixel_valid(pixel_valid),
      .horizontal_sync_in(horizontal_sync_in),
      .vertical_sync_in(vertical_sync_in), .window_out(window_out),
      .window_in_active(window_in_active), .port_out(port_out));
   engine_model eng_a (.pclk(pclk), .presetn(presetn), .consume(1'b1),
      .port_out(port_out), .lines(lines_a), .pixels(pixels_a),
      .first_data(first_a));
   engine_model eng_b (.pclk(pclk), .presetn(presetn), .consume(1'b0),
      .port_out(port_out), .lines(lines_b), .pixels(pixels_b),
      .first_data());

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // ----------------------------------------
   // window and sync monitor
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_px    <= 0;
         win_act   <= 0;
         win_syn   <= 0;
         port_vs   <= 0;
         win_first <= 10'h000;
         win_prev  <= 1'b0;
      end else begin
         win_prev <= window_out.valid;
         if (window_out.valid === 1'b1) win_px <= win_px + 1;
         if (window_in_active === 1'b1) win_act <= win_act + 1;
         win_syn <= win_syn + int'(window_out.hsync === 1'b1) +
                    int'(window_out.vsync === 1'b1);
         port_vs <= port_vs + int'(port_out.vsync === 1'b1);
         // first window pixel of each line
         if (window_out.valid === 1'b1 && win_prev !== 1'b1) begin
            win_first <= window_out.data;
         end
      end
   end

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle count assumed: only the watchdog ends a hung wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic frame(input int sh);
      @(posedge pclk);
      vertical_sync_in <= 1'b1;
      @(posedge pclk);
      vertical_sync_in <= 1'b0;
      for (int l = 0; l < 8; l++) begin
         @(posedge pclk);
         horizontal_sync_in <= 1'b1;
         @(posedge pclk);
         horizontal_sync_in <= 1'b0;
         for (int p = 0; p < 30; p++) begin
            @(posedge pclk);
            pixel_valid <= 1'b1;
            sensor_data <= 16'(p) << sh;
         end
         @(posedge pclk);
         pixel_valid <= 1'b0;
      end
      repeat (4) @(posedge pclk);
   endtask

   // 3 output lines against 8 sensor lines keeps software legal
   task automatic run(input logic [31:0] ctl, input logic [3:0] off,
                      input int nl);
      int l0, p0, w0, a0, s0, v0;
      l0 = lines_a;
      p0 = pixels_a;
      w0 = win_px;
      a0 = win_act;
      s0 = win_syn;
      v0 = port_vs;
      apb(1'b1, 12'h008, 32'h0006_0050 | 32'(off), rd, err);
      apb(1'b1, 12'h00c, ctl, rd, err);
      frame(ctl[14:12] == 3'h7 ? 0 : 6 - int'(ctl[14:12]));
      chk(32'(lines_a - l0), 32'(nl));
      chk(32'(pixels_a - p0), 32'(nl * 5));
      if (nl > 0) chk({22'h0, first_a}, 32'(st + off));
      chk(32'(win_px - w0), 32'(win_exp));
      chk(32'(win_act - a0), 32'(act_exp));
      chk(32'(win_syn - s0), 32'h9);
      chk(32'(port_vs - v0), {31'h0, ctl[15]});
      if (ctl[14:12] != 3'h7) chk({22'h0, win_first}, 32'(st));
      apb(1'b0, 12'h00c, 32'h0, rd, err);
      chk(rd, ctl);
      apb(1'b0, 12'h010, 32'h0, rd, err);
      chk(rd, {17'h0, ctl[15], 14'(nl)});
      $display("frame test ctl=%h offset=%0d done", ctl, off);
   endtask

   task automatic results();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, pixel_valid} = 5'h00;
      {horizontal_sync_in, vertical_sync_in} = 2'h0;
      {paddr, pwdata, sensor_data} = '0;
      failures = 0;
      n_compared = 0;
      st = 2;
      win_exp = 120;
      act_exp = 120;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0, rd, err);
         chk(rd, vpw_pkg::reset_value);
         apb(1'b1, 12'(4 * i), 32'hffff_ffff, rd, err);
         apb(1'b0, 12'(4 * i), 32'h0, rd, err);
         chk(rd, i == 2 ? vpw_pkg::output_mask : vpw_pkg::window_mask);
      end
      apb(1'b1, 12'h020, 32'hffff_ffff, rd, err);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 12'h020, 32'h0, rd, err);
      chk(rd | {31'h0, ~err}, 32'h0);
      $display("register test done");
      apb(1'b1, 12'h000, 32'h0002_0014, rd, err);
      apb(1'b1, 12'h004, 32'h0001_0006, rd, err);
      for (int c = 0; c < 7; c++) run(32'h8000 | 32'(c) << 12, 4'h3, 3);
      run(32'h0000_f000, 4'h3, 0);
      run(32'h0000_6000, 4'hf, 0);
      run(32'h0000_e000, 4'hf, 3);
      // start 16 leaves 14 window pixels, plus 2 idle cycles, per line
      st = 16;
      win_exp = 84;
      act_exp = 96;
      apb(1'b1, 12'h000, 32'h0010_0014, rd, err);
      run(32'h0000_e000, 4'h4, 3);
      chk(32'(lines_b + pixels_b), 32'h0);
      results();
   end

   initial begin
      #(20 * 20000);
      failures++;
      results();
   end
endmodule // video_port_window_control_tb
